// ### hw/bbfc_host.v
`timescale 1ns/1ps
`include "bbfc_regs.vh"
module bbfc_host #(
  parameter BUSY_CYC = `BBFC_BUSY_CYC
) (
  input  wire                 sys_clk_i,   // 10 MHz clock
  input  wire                 resetn_i,    // async reset, low
  input  wire                 req_i,       // start an operation
  input  wire [2:0]           op_i,        // operation code
  input  wire [`BBFC_AW-1:0]  addr_i,      // byte address
  input  wire [`BBFC_DW-1:0]  wdata_i,     // data or command byte
  input  wire                 boot_i,      // target is boot block
  output wire                 ready_o,     // idle, may take req
  output reg                  done_o,      // op finished pulse
  output reg  [`BBFC_DW-1:0]  rdata_o,     // captured read byte
  output reg  [`BBFC_AW-1:0]  fl_addr_o,   // flash address
  output reg                  fl_ce_n_o,   // chip select, low
  output reg                  fl_oe_n_o,   // output gate, low
  output reg                  fl_we_n_o,   // write strobe, low
  output reg                  fl_rp_n_o,   // reset_powerdown_n
  output reg                  fl_wp_o,     // write protect high
  output reg                  fl_vpp_en_o, // program supply on
  output reg                  fl_id_hv_o,  // id pin high voltage
  output reg  [`BBFC_DW-1:0]  fl_dq_o,     // data pins out
  output reg                  fl_dq_oe_n_o,// data enable, low
  input  wire [`BBFC_DW-1:0]  fl_dq_i      // data pins in
);
  localparam S_IDLE = 3'h0;
  localparam S_W1   = 3'h1;
  localparam S_REC  = 3'h2;
  localparam S_W2   = 3'h3;
  localparam S_RD   = 3'h4;
  localparam S_BUSY = 3'h5;
  localparam S_RST  = 3'h6;
  localparam S_W3   = 3'h7;

  reg [2:0]          state_ff;
  reg [2:0]          op_ff;
  reg [16:0]         cnt_ff;
  reg [`BBFC_DW-1:0] dq_s1_ff;
  reg [`BBFC_DW-1:0] dq_s2_ff;

  assign ready_o = (state_ff == S_IDLE);

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
    end else begin
      dq_s1_ff <= fl_dq_i;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff     <= S_IDLE;
      op_ff        <= `BBFC_OP_READ;
      cnt_ff       <= 17'h00000;
      done_o       <= 1'b0;
      rdata_o      <= 8'h00;
      fl_addr_o    <= 18'h00000;
      fl_ce_n_o    <= 1'b1;
      fl_oe_n_o    <= 1'b1;
      fl_we_n_o    <= 1'b1;
      fl_rp_n_o    <= 1'b0;
      fl_wp_o      <= 1'b0;
      fl_vpp_en_o  <= 1'b0;
      fl_id_hv_o   <= 1'b0;
      fl_dq_o      <= 8'h00;
      fl_dq_oe_n_o <= 1'b1;
    end else begin
      done_o    <= 1'b0;
      fl_rp_n_o <= 1'b1;
      case (state_ff)
        S_IDLE: begin
          // R3 deselect idle
          fl_ce_n_o    <= 1'b1;
          fl_oe_n_o    <= 1'b1;
          fl_we_n_o    <= 1'b1;
          fl_dq_oe_n_o <= 1'b1;
          fl_id_hv_o   <= 1'b0;
          if (req_i) begin
            op_ff     <= op_i;
            fl_addr_o <= addr_i;
            cnt_ff    <= 17'h00000;
            // R12 unlock boot
            fl_wp_o   <= boot_i;
            case (op_i)
              `BBFC_OP_READ, `BBFC_OP_IDENT: begin
                // R1 read strobe
                fl_ce_n_o  <= 1'b0;
                fl_oe_n_o  <= 1'b0;
                // R17 id select
                fl_id_hv_o <= (op_i == `BBFC_OP_IDENT);
                state_ff   <= S_RD;
              end
              `BBFC_OP_RESET: begin
                // R10 power-down pulse
                fl_rp_n_o <= 1'b0;
                state_ff  <= S_RST;
              end
              default: begin
                // R5 R6 write cycle
                fl_ce_n_o    <= 1'b0;
                fl_we_n_o    <= 1'b0;
                fl_dq_oe_n_o <= 1'b0;
                if (op_i == `BBFC_OP_ERASE)
                  fl_dq_o <= `BBFC_CMD_ERASE;
                else if (op_i == `BBFC_OP_PROG)
                  fl_dq_o <= `BBFC_CMD_PROG_B;
                else
                  fl_dq_o <= wdata_i;
                state_ff <= S_W1;
              end
            endcase
          end
        end
        S_RD: begin
          // R2 hold until sampled
          if (cnt_ff == `BBFC_CYC_ACC + `BBFC_SYNC_LAT) begin
            rdata_o    <= dq_s2_ff;
            fl_ce_n_o  <= 1'b1;
            fl_oe_n_o  <= 1'b1;
            fl_id_hv_o <= 1'b0;
            done_o     <= 1'b1;
            state_ff   <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 17'h00001;
          end
        end
        S_W1: begin
          if (cnt_ff == `BBFC_CYC_ACC - 1) begin
            fl_we_n_o <= 1'b1;
            cnt_ff    <= 17'h00000;
            state_ff  <= S_REC;
          end else begin
            cnt_ff <= cnt_ff + 17'h00001;
          end
        end
        S_REC: begin
          fl_ce_n_o    <= 1'b1;
          fl_dq_oe_n_o <= 1'b1;
          if (op_ff == `BBFC_OP_CMD) begin
            done_o   <= 1'b1;
            state_ff <= S_IDLE;
          end else begin
            // R7 R8 second cycle
            fl_ce_n_o    <= 1'b0;
            fl_we_n_o    <= 1'b0;
            fl_dq_oe_n_o <= 1'b0;
            // R19 supply on
            fl_vpp_en_o  <= 1'b1;
            fl_dq_o <= (op_ff == `BBFC_OP_ERASE) ? `BBFC_CMD_COMMIT
                                                 : wdata_i;
            state_ff <= S_W2;
          end
        end
        S_W2: begin
          if (cnt_ff == `BBFC_CYC_ACC - 1) begin
            // select and data held past the strobe rise
            fl_we_n_o    <= 1'b1;
            cnt_ff       <= 17'h00000;
            state_ff     <= S_BUSY;
          end else begin
            cnt_ff <= cnt_ff + 17'h00001;
          end
        end
        S_BUSY: begin
          // release select and data after strobe rose
          fl_ce_n_o    <= 1'b1;
          fl_dq_oe_n_o <= 1'b1;
          // R18 R19 wait internal algorithm
          if (cnt_ff == BUSY_CYC[16:0]) begin
            fl_vpp_en_o  <= 1'b0;
            fl_wp_o      <= 1'b0;
            fl_ce_n_o    <= 1'b0;
            fl_we_n_o    <= 1'b0;
            fl_dq_oe_n_o <= 1'b0;
            // R9 back to read array
            fl_dq_o      <= `BBFC_CMD_READ;
            cnt_ff       <= 17'h00000;
            state_ff     <= S_W3;
          end else begin
            cnt_ff <= cnt_ff + 17'h00001;
          end
        end
        S_W3: begin
          if (cnt_ff == `BBFC_CYC_ACC - 1) begin
            // select and data drop in idle, after the strobe
            fl_we_n_o    <= 1'b1;
            done_o       <= 1'b1;
            state_ff     <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 17'h00001;
          end
        end
        S_RST: begin
          // R11 hold power-down
          fl_rp_n_o <= 1'b0;
          if (cnt_ff == `BBFC_CYC_ACC - 1) begin
            fl_rp_n_o <= 1'b1;
            done_o    <= 1'b1;
            state_ff  <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 17'h00001;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule

// ### hw/bbfc_regs.vh
// Notes on behaviour
// R1 - read: chip select and output gate low, write strobe high, byte driven.
// R2 - read data stays valid until address changes or a gate rises.
// R3 - chip select high disables the device, data pins high impedance.
// R4 - output gate high disables data buffers even when selected.
// R5 - selected cycle with write strobe low is a write cycle.
// R6 - command bytes are written over the eight data pins.
// R7 - block erase: setup byte then confirm byte, back to back.
// R8 - byte program: setup code (either of two) then address and data.
// R9 - host writes read-array command before reading after program/erase.
// R10 - reset/power-down low clears status, read mode, deep power-down.
// R11 - during reset/power-down all inputs ignored, outputs high impedance.
// R12 - boot block change needs super voltage on reset or write-protect high.
// R13 - write-protect does not affect non-boot blocks.
// R14 - array has five erasable blocks: boot, two parameter, two main.
// R15 - boot block at top or bottom of address space by variant.
// R16 - eighteen address bits select one byte.
// R17 - id codes read with id pin high, lowest address bit selects code.
// R18 - after confirm the device runs its own internal algorithm.
// R19 - host holds program supply high from confirm until completion.
`ifndef BBFC_REGS_VH
`define BBFC_REGS_VH
`define BBFC_AW          18
`define BBFC_DW          8
`define BBFC_CMD_ERASE   8'h20
`define BBFC_CMD_COMMIT  8'hD0
`define BBFC_CMD_PROG_A  8'h10
`define BBFC_CMD_PROG_B  8'h40
`define BBFC_CMD_READ    8'hFF
`define BBFC_CMD_IDENT   8'h90
`define BBFC_ID_ADDR     18'h00000
`define BBFC_ID_DEV_ADDR 18'h00001
// access pulse width and recovery in ns
`define BBFC_T_ACC_NS    200
`define BBFC_T_REC_NS    100
`define BBFC_CLK_NS      100
`define BBFC_CYC_ACC     ((`BBFC_T_ACC_NS + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
`define BBFC_CYC_REC     ((`BBFC_T_REC_NS + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
// extra read wait for the two-flop data synchroniser
`define BBFC_SYNC_LAT    2
// busy wait for internal algorithm, cycles
`define BBFC_BUSY_CYC    100000
`define BBFC_OP_READ     3'h0
`define BBFC_OP_CMD      3'h1
`define BBFC_OP_PROG     3'h2
`define BBFC_OP_ERASE    3'h3
`define BBFC_OP_IDENT    3'h4
`define BBFC_OP_RESET    3'h5
`endif

// ### dv/bbfc_host_asserts.sv
`timescale 1ns/1ps
module bbfc_host_asserts (
  input wire logic        sys_clk_i,   // clk
  input wire logic        resetn_i,    // rst
  input wire logic        boot_i,      // boot
  input wire logic [17:0] fl_addr_o,   // addr
  input wire logic        fl_ce_n_o,   // ce
  input wire logic        fl_oe_n_o,   // oe
  input wire logic        fl_we_n_o,   // we
  input wire logic        fl_wp_o,     // wp
  input wire logic        fl_vpp_en_o, // vpp
  input wire logic        fl_id_hv_o,  // id
  input wire logic [7:0]  fl_dq_o,     // dq
  input wire logic        fl_dq_oe_n_o // dq en
);
  logic arm_ff;
  logic pend_ff;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // program setup seen, confirm pending read-array
  always @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i) begin
      arm_ff  <= 1'h0;
      pend_ff <= 1'h0;
    end else if ($fell(fl_we_n_o)) begin
      arm_ff <= !arm_ff && (fl_dq_o == 8'h40 || fl_dq_o == 8'h10);
      if (arm_ff || fl_dq_o == 8'hD0) pend_ff <= 1'h1;
      else if (fl_dq_o == 8'hFF) pend_ff <= 1'h0;
    end
  read_cycle_a: assert property ($fell(fl_oe_n_o) |->
    !fl_ce_n_o && fl_we_n_o && fl_dq_oe_n_o) else $error("bad read");
  cmd_write_a: assert property (!fl_we_n_o |->
    !fl_ce_n_o && fl_oe_n_o && !fl_dq_oe_n_o) else $error("bad write");
  erase_pair_a: assert property ($fell(fl_we_n_o) && !arm_ff &&
    fl_dq_o == 8'h20 |-> ##[1:8] ($fell(fl_we_n_o) && fl_dq_o == 8'hD0))
    else $error("no confirm");
  prog_pair_a: assert property ($fell(fl_we_n_o) && !arm_ff &&
    fl_dq_o == 8'h40 |-> ##[1:8] $fell(fl_we_n_o)) else $error("no data");
  read_array_a: assert property (!fl_oe_n_o |-> !pend_ff)
    else $error("read before FF");
  boot_unlock_a: assert property ($fell(fl_we_n_o) && boot_i &&
    fl_vpp_en_o |-> fl_wp_o) else $error("wp low");
  id_addr_a: assert property (fl_id_hv_o && !fl_oe_n_o |->
    fl_addr_o[17:1] == 17'h0) else $error("id addr");
  vpp_on_a: assert property ($fell(fl_we_n_o) &&
    (arm_ff || fl_dq_o == 8'hD0) |-> fl_vpp_en_o) else $error("vpp off");
endmodule

// ### dv/bbfc_flash_model.sv
`timescale 1ns/1ps
module bbfc_flash_model #(
  parameter [7:0] MFR_ID = 8'hA5, // arbitrary
  parameter [7:0] DEV_ID = 8'h3C  // arbitrary
) (
  input  wire logic [17:0] addr_i,  // addr
  input  wire logic        ce_n_i,  // select
  input  wire logic        oe_n_i,  // gate
  input  wire logic        we_n_i,  // strobe
  input  wire logic        rp_n_i,  // reset_powerdown_n
  input  wire logic        wp_i,    // protect
  input  wire logic        id_hv_i, // id pin
  input  wire logic [7:0]  dq_i,    // data in
  output wire logic [7:0]  dq_o     // data out
);
  logic [7:0] mem [int];
  logic [7:0] last = 8'h00;
  int         mode = 0;
  wire        drive = rp_n_i && !ce_n_i && !oe_n_i && we_n_i;
  function automatic [7:0] rv(input [17:0] a, input int m, input h);
    if (h || m == 1) return a[0] ? DEV_ID : MFR_ID;
    if (m == 4) return 8'h80;
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  function automatic int blk(input int a);
    return a >= 'h3C000 ? 0 : a >= 'h3A000 ? 1 : a >= 'h38000 ? 2 :
      a >= 'h20000 ? 3 : 4;
  endfunction
  assign dq_o = drive ? rv(addr_i, mode, id_hv_i) : ~last;
  always @* if (drive) last = dq_o;
  always @(negedge rp_n_i) mode = 0;
  always @(posedge we_n_i) if (rp_n_i && !ce_n_i) begin
    if (mode == 2 && (addr_i < 18'h3C000 || wp_i)) mem[addr_i] = dq_i;
    if (mode == 3 && dq_i == 8'hD0 && (addr_i < 18'h3C000 || wp_i))
      foreach (mem[a]) if (blk(a) == blk(addr_i)) mem[a] = 8'hFF;
    mode = (mode == 2 || mode == 3) ? 4 : dq_i == 8'h20 ? 3 :
      dq_i == 8'h90 ? 1 : (dq_i == 8'h10 || dq_i == 8'h40) ? 2 :
      dq_i == 8'hFF ? 0 : mode;
  end
endmodule

// ### dv/test_bbfc_host.sv
`timescale 1ns/1ps
module test_bbfc_host;
  localparam [7:0] MFR = 8'hA5; // arbitrary
  localparam [7:0] DEV = 8'h3C; // arbitrary
  logic sys_clk_i = 0, resetn_i = 0, req_i = 0, boot_i = 0;
  logic [2:0] op_i = 0;
  logic [17:0] addr_i = 0, fl_addr_o;
  logic [7:0] wdata_i = 0, rdata_o, fl_dq_o, fdq, fl_dq_i;
  logic ready_o, done_o, ce, oe, we, rp, wp, vpp, hv, dqen;
  logic [7:0] ref_m [int];
  logic [31:0] seed = 35;
  int fails = 0, n_tests = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  assign fl_dq_i = dqen ? fdq : fl_dq_o;
  bbfc_host #(.BUSY_CYC(20)) bbfc_host_inst (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .req_i(req_i), .op_i(op_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .boot_i(boot_i), .ready_o(ready_o), .done_o(done_o),
    .rdata_o(rdata_o), .fl_addr_o(fl_addr_o), .fl_ce_n_o(ce), .fl_oe_n_o(oe),
    .fl_we_n_o(we), .fl_rp_n_o(rp), .fl_wp_o(wp), .fl_vpp_en_o(vpp),
    .fl_id_hv_o(hv), .fl_dq_o(fl_dq_o), .fl_dq_oe_n_o(dqen), .fl_dq_i(fl_dq_i));
  bbfc_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) bbfc_flash_model_inst (
    .addr_i(fl_addr_o), .ce_n_i(ce), .oe_n_i(oe), .we_n_i(we), .rp_n_i(rp),
    .wp_i(wp), .id_hv_i(hv), .dq_i(fl_dq_o), .dq_o(fdq));
  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic [7:0] fv(input [17:0] a);
    return ref_m.exists(a) ? ref_m[a] : 8'hFF;
  endfunction
  task automatic conclude();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic run(input [2:0] o, input [17:0] a, input [7:0] d, input b);
    int k = 0;
    @(negedge sys_clk_i);
    chk({7'h00, ready_o}, 8'h01);
    {req_i, op_i, addr_i, wdata_i, boot_i} = {1'h1, o, a, d, b};
    @(negedge sys_clk_i);
    req_i = 1'h0;
    while (done_o !== 1'h1 && k < 400) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k == 400) begin
      fails++;
      $display("BAD %0t no done", $time);
    end
  endtask
  task automatic chk(input [7:0] got, input [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input [17:0] a);
    run(3'h0, a, 8'h00, 1'h0);
    chk(rdata_o, fv(a));
  endtask
  task automatic prog(input [17:0] a, input [7:0] d, input b);
    run(3'h2, a, d, b);
    if (a < 18'h3C000 || b) ref_m[a] = d;
  endtask
  task automatic er(input [17:0] a, input [17:0] lo, input b);
    run(3'h3, a, 8'h00, b);
    if (a < 18'h3C000 || b)
      foreach (ref_m[k]) if (k >= lo && k <= a + 18'h01FFF) ref_m[k] = 8'hFF;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk_i);
    resetn_i = 1'h1;
    rd(18'h00000);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      prog({1'h0, seed[16:0]}, seed[31:24], 1'h0);
      rd({1'h0, seed[16:0]});
    end
    prog(18'h3FFFF, 8'h5A, 1'h0);
    rd(18'h3FFFF);
    prog(18'h3FFFF, 8'h5A, 1'h1);
    rd(18'h3FFFF);
    prog(18'h3A005, 8'h12, 1'h0);
    er(18'h3A000, 18'h3A000, 1'h0);
    rd(18'h3A005);
    er(18'h3C000, 18'h3C000, 1'h0);
    rd(18'h3FFFF);
    run(3'h4, 18'h00000, 8'h00, 1'h0);
    chk(rdata_o, MFR);
    run(3'h4, 18'h00001, 8'h00, 1'h0);
    chk(rdata_o, DEV);
    run(3'h1, 18'h00000, 8'h90, 1'h0);
    run(3'h0, 18'h00001, 8'h00, 1'h0);
    chk(rdata_o, DEV);
    run(3'h5, 18'h00000, 8'h00, 1'h0);
    rd(18'h3FFFF);
    conclude();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fails++;
    conclude();
  end
endmodule
bind bbfc_host bbfc_host_asserts bbfc_host_asserts_inst (.sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i), .boot_i(boot_i), .fl_addr_o(fl_addr_o),
  .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o),
  .fl_wp_o(fl_wp_o), .fl_vpp_en_o(fl_vpp_en_o), .fl_id_hv_o(fl_id_hv_o),
  .fl_dq_o(fl_dq_o), .fl_dq_oe_n_o(fl_dq_oe_n_o));
